// >>> rtl/dual_eight_bit_timer.sv
// Module: two-channel 8-bit timer with cascade, compare outputs and AXI4-Lite registers
// Behaviour
// - Match A select: keep, low, high, toggle
// - Match B same; toggle beats high beats low
// - Flags clear by read-one then write-zero
// - Stop bit 12 halts timer after access
// - Module stop ignores channel register reads, writes
// - Stop register resets to 3FFF
// - Internal counts at clock over 8/64/8192
// - External counts rising, falling or both edges
// - Match flags set just before next count
// - Counter clears on match A or B
// - Counter clears on external reset rise
// - Wrap flag set on FF to 00
// - Code 100 in either channel cascades
// - Channel 0 code 100: 16-bit, ch0 upper; here ch1 steps on ch0's code 100 source, so neither counts
// - 16-bit: ch0 full match, ch1 low byte
// - 16-bit: ch0 clear whole, ch1 ignored
// - 16-bit: outputs follow their match conditions
// - Channel 1 code 100 counts ch0 match A
// - Both code 100: no counting at all
// - Three gated requests per channel
// - Fixed default priority order of requests
// - Converter start only on ch0 match A
//
// The AXI4-Lite interface to the registers and the placing of the registers are this design's own decisions.
`timescale 1ns/10ps
module dual_eight_bit_timer (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic [5:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [5:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic [1:0]  ext_clock_in,
    input  wire logic [1:0]  ext_clear_in,
    output logic             wave_out_ch0,
    output logic             wave_out_ch1,
    output logic [1:0]       match_a_request,
    output logic [1:0]       match_b_request,
    output logic [1:0]       wrap_request,
    output logic [5:0]       request_by_priority,
    output logic             converter_start
);

    // ************************************************************
    // Register storage
    // ************************************************************
    logic [7:0]  ctrl_q   [2];
    logic [7:0]  csr_q    [2];
    logic [7:0]  cmpa_q   [2];
    logic [7:0]  cmpb_q   [2];
    logic [7:0]  cnt_q    [2];
    logic [15:0] mstop_q;
    logic [2:0]  rd_armed_q [2];  // Flags seen as one by a read
    logic [1:0]  ext_clk_q;
    logic [1:0]  ext_clr_q;
    localparam int PRESC_W = tmr_pkg::PRESCALE_W;
    logic [PRESC_W-1:0] presc_q;

    // ************************************************************
    // Bus handshake
    // ************************************************************
    logic        bvalid_q;
    logic        rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0]  rresp_q;
    logic [1:0]  bresp_q;
    logic        stopped;
    logic        wr_fire;
    logic        rd_fire;
    logic [3:0]  wr_idx;
    logic [3:0]  rd_idx;
    logic        wr_ok;
    logic        rd_ok;
    logic [31:0] rd_word;

    assign stopped = mstop_q[tmr_pkg::TIMER_STOP_BIT];

    // Write takes both channels together; simple and no skid storage needed
    assign s_axi_awready = s_axi_awvalid & s_axi_wvalid & ~bvalid_q;
    assign s_axi_wready  = s_axi_awready;
    assign wr_fire       = s_axi_awready;
    assign s_axi_arready = s_axi_arvalid & ~rvalid_q;
    assign rd_fire       = s_axi_arready;

    // Word index from byte address
    function automatic logic [3:0] word_idx(input logic [5:0] a);
        return a[5:2];
    endfunction : word_idx

    // Registers 0..9 are the channels; 10 is module stop
    function automatic logic idx_valid(input logic [3:0] i, input logic stop);
        return (i == 4'hA) || ((i < 4'hA) && !stop);
    endfunction : idx_valid

    assign wr_idx = word_idx(s_axi_awaddr);
    assign rd_idx = word_idx(s_axi_araddr);
    assign wr_ok  = idx_valid(wr_idx, stopped) & s_axi_wstrb[0];
    assign rd_ok  = idx_valid(rd_idx, stopped);

    // ************************************************************
    // Prescaler and count sources
    // ************************************************************
    logic [PRESC_W-1:0] presc_d;
    logic [1:0] tick_int;
    logic [1:0] tick_ext;
    logic [1:0] tick;
    logic [2:0] cks [2];
    logic       mode16;
    logic       mode_cmc;
    logic       both_casc;
    logic       p8;
    logic       p64;
    logic       p8192;

    assign presc_d = presc_q + PRESC_W'(1);
    // Pulses on each wrap of the low bits (falling edge of divided clock)
    assign p8    = (presc_q[2:0] == 3'h7);
    assign p64   = (presc_q[5:0] == 6'h3F);
    assign p8192 = (presc_q == {PRESC_W{1'b1}});

    assign cks[0]    = ctrl_q[0][2:0];
    assign cks[1]    = ctrl_q[1][2:0];
    assign mode16    = (cks[0] == tmr_pkg::CKS_CASCADE);
    assign mode_cmc  = (cks[1] == tmr_pkg::CKS_CASCADE);
    assign both_casc = mode16 & mode_cmc;

    logic [1:0] ext_rise;
    logic [1:0] ext_fall;
    logic [1:0] clr_rise;
    assign ext_rise = ext_clock_in & ~ext_clk_q;
    assign ext_fall = ~ext_clock_in & ext_clk_q;
    assign clr_rise = ext_clear_in & ~ext_clr_q;

    // Source selection per channel code
    function automatic logic pick(input logic [2:0] c, input logic r, input logic f,
                                  input logic q8, input logic q64, input logic q8k);
        case (c)
            tmr_pkg::CKS_DIV8:    return q8;
            tmr_pkg::CKS_DIV64:   return q64;
            tmr_pkg::CKS_DIV8192: return q8k;
            tmr_pkg::CKS_EXT_R:   return r;
            tmr_pkg::CKS_EXT_F:   return f;
            tmr_pkg::CKS_EXT_B:   return r | f;
            default:              return 1'b0;
        endcase
    endfunction : pick

    assign tick_int[0] = pick(cks[0], ext_rise[0], ext_fall[0], p8, p64, p8192);
    assign tick_int[1] = pick(cks[1], ext_rise[1], ext_fall[1], p8, p64, p8192);

    // ************************************************************
    // Compare and count
    // ************************************************************
    logic [1:0] eq_a;
    logic [1:0] eq_b;
    logic [1:0] hit_a;
    logic [1:0] hit_b;
    logic [1:0] clr_cnt;
    logic [1:0] wrap;
    logic       ch1_carry;
    logic       src16;
    logic [1:0] clr_sel [2];

    assign clr_sel[0] = ctrl_q[0][tmr_pkg::CTRL_CLR_LSB +: 2];
    assign clr_sel[1] = ctrl_q[1][tmr_pkg::CTRL_CLR_LSB +: 2];

    // Channel 0 equality needs the low byte too in 16-bit mode
    assign eq_a[0] = (cnt_q[0] == cmpa_q[0]) & (!mode16 | (cnt_q[1] == cmpa_q[1]));
    assign eq_b[0] = (cnt_q[0] == cmpb_q[0]) & (!mode16 | (cnt_q[1] == cmpb_q[1]));
    assign eq_a[1] = (cnt_q[1] == cmpa_q[1]);
    assign eq_b[1] = (cnt_q[1] == cmpb_q[1]);

    // Match fires in the last equal cycle, i.e. when the next count tick comes
    // Own 16-bit step term, so no loop runs through hit_a[0]
    assign src16       = ~stopped & ~both_casc & tick_int[0];
    assign ch1_carry   = src16 & (cnt_q[1] == 8'hFF);
    assign tick[1]     = ~stopped & ~both_casc &
                         (mode_cmc ? hit_a[0] : (mode16 ? tick_int[0] : tick_int[1]));
    // In 16-bit mode ch1 steps on ch0's source; ch0 steps on ch1's carry
    assign tick[0]     = ~stopped & ~both_casc &
                         (mode16 ? ch1_carry : tick_int[0]);
    assign hit_a[0]    = ~stopped & eq_a[0] & (mode16 ? src16 : tick[0]);
    assign hit_b[0]    = ~stopped & eq_b[0] & (mode16 ? src16 : tick[0]);
    assign hit_a[1]    = eq_a[1] & tick[1];
    assign hit_b[1]    = eq_b[1] & tick[1];

    // Clear decision; ch1 follows ch0 when joined
    function automatic logic clr_hit(input logic [1:0] s, input logic a, input logic b,
                                     input logic e);
        case (s)
            tmr_pkg::CLR_MATCH_A: return a;
            tmr_pkg::CLR_MATCH_B: return b;
            tmr_pkg::CLR_EXT:     return e;
            default:              return 1'b0;
        endcase
    endfunction : clr_hit

    assign clr_cnt[0] = ~stopped & clr_hit(clr_sel[0], hit_a[0], hit_b[0], clr_rise[0]);
    assign clr_cnt[1] = mode16 ? clr_cnt[0] :
                        (~stopped & clr_hit(clr_sel[1], hit_a[1], hit_b[1], clr_rise[1]));
    assign wrap[0]    = tick[0] & ~clr_cnt[0] & (cnt_q[0] == 8'hFF);
    assign wrap[1]    = tick[1] & ~clr_cnt[1] & (cnt_q[1] == 8'hFF) & ~mode16;

    // ************************************************************
    // Flags and software access
    // ************************************************************
    logic [2:0] hw_set   [2];
    logic [2:0] sw_clr   [2];
    logic [2:0] flags    [2];
    logic [1:0] wr_ch;
    logic [1:0] rd_ch;
    logic [3:0] wr_reg;

    function automatic logic [2:0] flag_bits(input logic [7:0] s);
        return s[tmr_pkg::CSR_FLAG_B_BIT -: 3];
    endfunction : flag_bits

    assign wr_ch[0] = wr_fire & wr_ok & (wr_idx < 4'h5);
    assign wr_ch[1] = wr_fire & wr_ok & (wr_idx >= 4'h5) & (wr_idx < 4'hA);
    assign wr_reg   = wr_ch[1] ? (wr_idx - 4'h5) : wr_idx;

    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_ch
            assign flags[g]  = flag_bits(csr_q[g]);
            assign hw_set[g] = {hit_b[g], hit_a[g], wrap[g]};
            // Zero written over an armed flag clears it; writing one does nothing
            assign sw_clr[g] = (wr_ch[g] && wr_reg == 4'h1) ?
                               (rd_armed_q[g] & ~s_axi_wdata[7:5]) : 3'b000;
        end
    endgenerate

    // Count writes lose to clear, beat increment
    always_ff @(posedge clk) begin
        if (rst) begin
            for (int i = 0; i < 2; i++) begin
                cnt_q[i]      <= 8'h00;
                ctrl_q[i]     <= 8'h00;
                cmpa_q[i]     <= tmr_pkg::CMP_RESET;
                cmpb_q[i]     <= tmr_pkg::CMP_RESET;
                rd_armed_q[i] <= 3'b000;
            end
            csr_q[0] <= tmr_pkg::CSR0_RESET;
            csr_q[1] <= tmr_pkg::CSR1_RESET;
            mstop_q  <= tmr_pkg::MSTOP_RESET;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (clr_cnt[i]) begin
                    cnt_q[i] <= 8'h00;
                end else if (wr_ch[i] && wr_reg == 4'h4) begin
                    cnt_q[i] <= s_axi_wdata[7:0];
                end else if (tick[i]) begin
                    cnt_q[i] <= cnt_q[i] + 8'h01;
                end
                if (wr_ch[i] && wr_reg == 4'h0) begin
                    ctrl_q[i] <= s_axi_wdata[7:0];
                end
                if (wr_ch[i] && wr_reg == 4'h2) begin
                    cmpa_q[i] <= s_axi_wdata[7:0];
                end
                if (wr_ch[i] && wr_reg == 4'h3) begin
                    cmpb_q[i] <= s_axi_wdata[7:0];
                end
                // Hardware set wins over a same-cycle clear
                csr_q[i][7:5] <= (flags[i] & ~sw_clr[i]) | hw_set[i];
                if (wr_ch[i] && wr_reg == 4'h1) begin
                    csr_q[i][3:0] <= s_axi_wdata[3:0];
                    if (i == 0) begin
                        csr_q[i][tmr_pkg::CSR_CONVERTER_TRIGGER_ENABLE_BIT] <= s_axi_wdata[4];
                    end
                end
                if (rd_fire && rd_ok && rd_idx == 4'(i * 5 + 1)) begin
                    rd_armed_q[i] <= flags[i];
                end else if (wr_ch[i] && wr_reg == 4'h1) begin
                    rd_armed_q[i] <= 3'b000;
                end
            end
            if (wr_fire && wr_ok && wr_idx == 4'hA) begin
                mstop_q[7:0] <= s_axi_wdata[7:0];
            end
            if (wr_fire && wr_idx == 4'hA && s_axi_wstrb[1]) begin
                mstop_q[15:8] <= s_axi_wdata[15:8];
            end
        end
    end

    // Pin history and prescaler
    always_ff @(posedge clk) begin
        if (rst) begin
            ext_clk_q <= 2'b00;
            ext_clr_q <= 2'b00;
            presc_q   <= '0;
        end else begin
            ext_clk_q <= ext_clock_in;
            ext_clr_q <= ext_clear_in;
            presc_q   <= stopped ? '0 : presc_d;
        end
    end

    // ************************************************************
    // Read mux and responses
    // ************************************************************
    always_comb begin
        rd_word = 32'h0000_0000;
        case (rd_idx)
            4'h0: rd_word = {24'h00_0000, ctrl_q[0]};
            4'h1: rd_word = {24'h00_0000, csr_q[0]};
            4'h2: rd_word = {24'h00_0000, cmpa_q[0]};
            4'h3: rd_word = {24'h00_0000, cmpb_q[0]};
            4'h4: rd_word = {24'h00_0000, cnt_q[0]};
            4'h5: rd_word = {24'h00_0000, ctrl_q[1]};
            4'h6: rd_word = {24'h00_0000, csr_q[1]};
            4'h7: rd_word = {24'h00_0000, cmpa_q[1]};
            4'h8: rd_word = {24'h00_0000, cmpb_q[1]};
            4'h9: rd_word = {24'h00_0000, cnt_q[1]};
            4'hA: rd_word = {16'h0000, mstop_q};
            default: rd_word = 32'h0000_0000;
        endcase
    end

    // Stopped or unmapped accesses answer SLVERR and read zero
    always_ff @(posedge clk) begin
        if (rst) begin
            bvalid_q <= 1'b0;
            rvalid_q <= 1'b0;
            rdata_q  <= 32'h0000_0000;
            rresp_q  <= tmr_pkg::RESP_OKAY;
            bresp_q  <= tmr_pkg::RESP_OKAY;
        end else begin
            if (wr_fire) begin
                bvalid_q <= 1'b1;
                bresp_q  <= idx_valid(wr_idx, stopped) ? tmr_pkg::RESP_OKAY : tmr_pkg::RESP_SLVERR;
            end else if (s_axi_bready) begin
                bvalid_q <= 1'b0;
            end
            if (rd_fire) begin
                rvalid_q <= 1'b1;
                rdata_q  <= rd_ok ? rd_word : 32'h0000_0000;
                rresp_q  <= rd_ok ? tmr_pkg::RESP_OKAY : tmr_pkg::RESP_SLVERR;
            end else if (s_axi_rready) begin
                rvalid_q <= 1'b0;
            end
        end
    end

    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp  = bresp_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata  = rdata_q;
    assign s_axi_rresp  = rresp_q;

    // ************************************************************
    // Requests and outputs
    // ************************************************************
    logic conv_q;
    for (genvar c = 0; c < 2; c++) begin : g_req
        assign match_a_request[c] = csr_q[c][tmr_pkg::CSR_FLAG_A_BIT] &
                                    ctrl_q[c][tmr_pkg::CTRL_IEA_BIT];
        assign match_b_request[c] = csr_q[c][tmr_pkg::CSR_FLAG_B_BIT] &
                                    ctrl_q[c][tmr_pkg::CTRL_IEB_BIT];
        assign wrap_request[c]    = csr_q[c][tmr_pkg::CSR_WRAP_BIT] &
                                    ctrl_q[c][tmr_pkg::CTRL_IEW_BIT];
    end
    // Bit 5 is highest priority
    assign request_by_priority = {match_a_request[0], match_b_request[0], wrap_request[0],
                                  match_a_request[1], match_b_request[1], wrap_request[1]};

    // Converter start is a one-cycle pulse on channel 0 match A
    always_ff @(posedge clk) begin
        if (rst) begin
            conv_q <= 1'b0;
        end else begin
            conv_q <= hit_a[0] & csr_q[0][tmr_pkg::CSR_CONVERTER_TRIGGER_ENABLE_BIT];
        end
    end
    assign converter_start = conv_q;

    // Wave pins; ch0 uses 16-bit hits in joined mode
    tmr_channel_out u_out0 (
        .clk      (clk),
        .rst      (rst),
        .match_a  (hit_a[0]),
        .match_b  (hit_b[0]),
        .sel_a    (csr_q[0][1:0]),
        .sel_b    (csr_q[0][3:2]),
        .wave_out (wave_out_ch0)
    );
    tmr_channel_out u_out1 (
        .clk      (clk),
        .rst      (rst),
        .match_a  (hit_a[1]),
        .match_b  (hit_b[1]),
        .sel_a    (csr_q[1][1:0]),
        .sel_b    (csr_q[1][3:2]),
        .wave_out (wave_out_ch1)
    );

endmodule : dual_eight_bit_timer

// >>> rtl/tmr_channel_out.sv
// Module: waveform output of one channel, driven by the two match actions
`timescale 1ns/10ps
module tmr_channel_out (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       match_a,
    input  wire logic       match_b,
    input  wire logic [1:0] sel_a,
    input  wire logic [1:0] sel_b,
    output logic            wave_out
);

    // ************************************************************
    // Action resolution
    // ************************************************************
    // Encoding value doubles as priority: toggle > high > low > keep
    logic [1:0] act_a;
    logic [1:0] act_b;
    logic [1:0] act;
    logic       wave_q;
    logic       wave_d;

    assign act_a = match_a ? sel_a : tmr_pkg::OS_KEEP;
    assign act_b = match_b ? sel_b : tmr_pkg::OS_KEEP;
    assign act   = (act_a > act_b) ? act_a : act_b;

    // Next level from the winning action
    always_comb begin
        case (act)
            tmr_pkg::OS_LOW:    wave_d = 1'b0;
            tmr_pkg::OS_HIGH:   wave_d = 1'b1;
            tmr_pkg::OS_TOGGLE: wave_d = ~wave_q;
            default:            wave_d = wave_q;
        endcase
    end

    // Output is low after reset until a first match acts
    always_ff @(posedge clk) begin
        if (rst) begin
            wave_q <= 1'b0;
        end else begin
            wave_q <= wave_d;
        end
    end

    assign wave_out = wave_q;

endmodule : tmr_channel_out

// >>> rtl/tmr_pkg.sv
// Package: register map, field positions, reset values and timing constants of the dual timer
package tmr_pkg;

    // ************************************************************
    // Register byte offsets (AXI4-Lite, one aligned word each)
    // ************************************************************
    localparam logic [5:0] OFF_CTRL0   = 6'h00;  // timer_control ch0
    localparam logic [5:0] OFF_CSR0    = 6'h04;  // timer_ctl_status ch0
    localparam logic [5:0] OFF_CMPA0   = 6'h08;  // compare_constant A ch0
    localparam logic [5:0] OFF_CMPB0   = 6'h0C;  // compare_constant B ch0
    localparam logic [5:0] OFF_CNT0    = 6'h10;  // timer_count ch0
    localparam logic [5:0] OFF_CTRL1   = 6'h14;
    localparam logic [5:0] OFF_CSR1    = 6'h18;
    localparam logic [5:0] OFF_CMPA1   = 6'h1C;
    localparam logic [5:0] OFF_CMPB1   = 6'h20;
    localparam logic [5:0] OFF_CNT1    = 6'h24;
    localparam logic [5:0] OFF_MSTOP   = 6'h28;  // module_stop_control
    localparam logic [5:0] CH_STRIDE   = 6'h14;

    // ************************************************************
    // Field positions
    // ************************************************************
    // timer_control: [2:0] clock select, [4:3] clear select, [5] A en, [6] B en, [7] wrap en
    localparam int CTRL_CKS_LSB   = 0;
    localparam int CTRL_CLR_LSB   = 3;
    localparam int CTRL_IEA_BIT   = 5;
    localparam int CTRL_IEB_BIT   = 6;
    localparam int CTRL_IEW_BIT   = 7;
    // timer_ctl_status
    localparam int CSR_FLAG_B_BIT = 7;
    localparam int CSR_FLAG_A_BIT = 6;
    localparam int CSR_WRAP_BIT   = 5;
    localparam int CSR_CONVERTER_TRIGGER_ENABLE_BIT   = 4;
    localparam int TIMER_STOP_BIT = 12;

    // ************************************************************
    // Reset values
    // ************************************************************
    localparam logic [15:0] MSTOP_RESET = 16'h3FFF;
    localparam logic [7:0]  CSR0_RESET  = 8'h00;
    localparam logic [7:0]  CSR1_RESET  = 8'h10;
    localparam logic [7:0]  CMP_RESET   = 8'hFF;

    // ************************************************************
    // Codes
    // ************************************************************
    localparam logic [2:0] CKS_OFF     = 3'h0;
    localparam logic [2:0] CKS_DIV8    = 3'h1;
    localparam logic [2:0] CKS_DIV64   = 3'h2;
    localparam logic [2:0] CKS_DIV8192 = 3'h3;
    localparam logic [2:0] CKS_CASCADE = 3'h4;
    localparam logic [2:0] CKS_EXT_R   = 3'h5;
    localparam logic [2:0] CKS_EXT_F   = 3'h6;
    localparam logic [2:0] CKS_EXT_B   = 3'h7;
    localparam logic [1:0] CLR_NONE    = 2'h0;
    localparam logic [1:0] CLR_MATCH_A = 2'h1;
    localparam logic [1:0] CLR_MATCH_B = 2'h2;
    localparam logic [1:0] CLR_EXT     = 2'h3;
    localparam logic [1:0] OS_KEEP     = 2'h0;
    localparam logic [1:0] OS_LOW      = 2'h1;
    localparam logic [1:0] OS_HIGH     = 2'h2;
    localparam logic [1:0] OS_TOGGLE   = 2'h3;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ************************************************************
    // Prescaler divide ratios
    // ************************************************************
    localparam int DIV_A = 8;
    localparam int DIV_B = 64;
    localparam int DIV_C = 8192;
    localparam int PRESCALE_W = 13;

endpackage : tmr_pkg

// >>> verification/tb.sv
// Testbench: stop control, internal and external counting, flags and outputs
`timescale 1ns/10ps
module tb;
    logic        clk = 0, rst = 1, awv = 0, wv = 0, arv = 0, run = 0, clr = 0, seen;
    logic [5:0]  awaddr = 0, araddr = 0, prio;
    logic [31:0] wdata = 0, rdata;
    logic        awready, wready, bvalid, arready, rvalid, w0, w1, conv;
    logic [1:0]  bresp, rresp, ra, rb, rw, eclk, eclr;
    int          err_total = 0, tests_run = 0, n;
    always #50 clk = ~clk;
    // Response channels always ready, so no answer is ever stalled
    dual_eight_bit_timer u_dual_eight_bit_timer (.clk, .rst, .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awv), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
        .s_axi_wvalid(wv), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(1'b1), .s_axi_araddr(araddr), .s_axi_arvalid(arv), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'b1),
        .ext_clock_in(eclk), .ext_clear_in(eclr), .wave_out_ch0(w0), .wave_out_ch1(w1),
        .match_a_request(ra), .match_b_request(rb), .wrap_request(rw),
        .request_by_priority(prio), .converter_start(conv));
    tmr_pins u_tmr_pins (.clk, .run, .clr, .ext_clock_in(eclk), .ext_clear_in(eclr));
    task automatic results;
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : results
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            $display("unexpected at %0t got %h expected %h", $time, got, exp);
            err_total++;
        end
    endtask : chk
    // One clock under a shared bound, so no wait hangs
    task automatic tick;
        @(posedge clk);
        n++;
        if (n > 3000) begin
            err_total++;
            results();
        end
    endtask : tick
    task automatic wr(input logic [5:0] a, input logic [31:0] d,
                      input logic [1:0] r = tmr_pkg::RESP_OKAY);
        {awaddr, wdata, awv, wv} <= {a, d, 2'b11};
        n = 0;
        do tick(); while (!awready);
        {awv, wv} <= 2'b00;
        chk(wready, 1);
        do tick(); while (!bvalid);
        chk({30'h0, bresp}, {30'h0, r});
    endtask : wr
    task automatic rd(input logic [5:0] a, input logic [31:0] e, input logic [1:0] r);
        {araddr, arv} <= {a, 1'b1};
        n = 0;
        do tick(); while (!arready);
        arv <= 0;
        do tick(); while (!rvalid);
        chk(rdata, e);
        chk({30'h0, rresp}, {30'h0, r});
    endtask : rd
    task automatic s_stop;
        rd(tmr_pkg::OFF_MSTOP, 32'h0000_3FFF, tmr_pkg::RESP_OKAY);
        wr(tmr_pkg::OFF_CNT0, 32'h5, tmr_pkg::RESP_SLVERR);
        rd(tmr_pkg::OFF_CNT0, 32'h0, tmr_pkg::RESP_SLVERR);
        wr(tmr_pkg::OFF_MSTOP, 32'h0);
        rd(tmr_pkg::OFF_CNT0, 32'h0, tmr_pkg::RESP_OKAY);
    endtask : s_stop
    // Divide by 8, clear and toggle on match A, converter trigger on
    task automatic s_match;
        wr(tmr_pkg::OFF_CMPA0, 32'h3);
        wr(tmr_pkg::OFF_CSR0, 32'h13);
        wr(tmr_pkg::OFF_CTRL0, 32'h29);
        {n, seen} = 0;
        // Start pulse stands only one cycle, so watch it while waiting
        do begin
            tick();
            seen |= conv;
        end while (!ra[0]);
        repeat (3) begin
            tick();
            seen |= conv;
        end
        chk(seen, 1);
        chk(w0, 1);
        rd(tmr_pkg::OFF_CSR0, 32'h53, tmr_pkg::RESP_OKAY);
        wr(tmr_pkg::OFF_CSR0, 32'h13);
        chk(ra[0], 0);
        wr(tmr_pkg::OFF_CTRL0, 32'h0);
    endtask : s_match
    // External rising edges through the wrap, then a pin clear
    task automatic s_ext;
        wr(tmr_pkg::OFF_CNT1, 32'hFE);
        wr(tmr_pkg::OFF_CTRL1, 32'h9D);
        run <= 1;
        do tick(); while (!rw[1]);
        run <= 0;
        chk(prio, 32'h1);
        chk({rb, w1}, 3'h0);
        rd(tmr_pkg::OFF_CSR1, 32'hF0, tmr_pkg::RESP_OKAY);
        wr(tmr_pkg::OFF_CNT1, 32'h40);
        clr <= 1;
        repeat (3) tick();
        clr <= 0;
        repeat (4) tick();
        rd(tmr_pkg::OFF_CNT1, 32'h0, tmr_pkg::RESP_OKAY);
    endtask : s_ext
    initial begin
        repeat (20) @(posedge clk);
        rst <= 0;
        s_stop();
        s_match();
        s_ext();
        results();
    end
endmodule : tb

// >>> verification/tmr_assertions.sv
// Checker: port-level properties of the dual timer
`timescale 1ns/10ps
module tmr_assertions (
    input wire logic       clk, rst, s_axi_awvalid, s_axi_wvalid, s_axi_awready,
    input wire logic       s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready,
    input wire logic       s_axi_rvalid, wave_out_ch0, wave_out_ch1, converter_start,
    input wire logic [1:0] match_a_request, match_b_request, wrap_request,
    input wire logic [5:0] request_by_priority
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // Bus answers come exactly one cycle after acceptance
    sequence s_wr_taken;
        s_axi_awvalid && s_axi_awready;
    endsequence
    a_wr_answer: assert property (s_wr_taken |=> s_axi_bvalid) else $error("no bvalid");
    a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("no rvalid");
    a_b_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("b");
    a_aw_gated: assert property (s_axi_awready |-> s_axi_wvalid && !s_axi_bvalid)
        else $error("write taken while busy");
    a_prio_order: assert property (request_by_priority ==
        {match_a_request[0], match_b_request[0], wrap_request[0],
         match_a_request[1], match_b_request[1], wrap_request[1]}) else $error("prio");
    a_conv_pulse: assert property (converter_start |=> !converter_start) else $error("conv");
    a_wave_reset: assert property ($fell(rst) |-> !wave_out_ch0 && !wave_out_ch1)
        else $error("wave after reset");
    a_req_reset: assert property ($fell(rst) |->
        (match_a_request | match_b_request | wrap_request) == 2'h0)
        else $error("request after reset");
endmodule : tmr_assertions
bind dual_eight_bit_timer tmr_assertions u_tmr_assertions (.clk, .rst, .s_axi_awvalid,
    .s_axi_wvalid, .s_axi_awready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rvalid, .wave_out_ch0, .wave_out_ch1, .converter_start, .match_a_request,
    .match_b_request, .wrap_request, .request_by_priority);

// >>> verification/tmr_pins.sv
// Partner: external count and clear pins
`timescale 1ns/10ps
module tmr_pins (
    input  wire logic  clk,
    input  wire logic  run,
    input  wire logic  clr,
    output logic [1:0] ext_clock_in,
    output logic [1:0] ext_clear_in
);
    logic [1:0] ph_q;
    // Levels held two clocks, above the minimum width; clock stands still when idle
    always_ff @(posedge clk) begin
        ph_q <= run ? ph_q + 2'h1 : 2'h0;
        ext_clock_in <= {2{run & ph_q[1]}};
        ext_clear_in <= {2{clr}};
    end
endmodule : tmr_pins
